// [verilog/pcrs_consts.svh]
`ifndef PCRS_CONSTS_SVH
`define PCRS_CONSTS_SVH

// ---------------------------------------------------------------
// Widths and stack depths
// ---------------------------------------------------------------
`define PCRS_PC_W       21
`define PCRS_PTR_W      6
`define PCRS_DEPTH      31
`define PCRS_DBG_DEPTH  35
`define PCRS_PC_STEP    21'h000002
`define PCRS_PTR_ZERO   6'h00
`define PCRS_PTR_ONE    6'h01

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PCRS_OFF_PCL    8'h00
`define PCRS_OFF_LATH   8'h04
`define PCRS_OFF_LATU   8'h08
`define PCRS_OFF_PTR    8'h0C
`define PCRS_OFF_TOP_OF_STACK_LOW   8'h10
`define PCRS_OFF_TOP_OF_STACK_HIGH   8'h14
`define PCRS_OFF_TOP_OF_STACK_UPPER   8'h18
`define PCRS_OFF_STAT   8'h1C
`define PCRS_OFF_CMD    8'h20

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PCRS_STAT_FULL  0
`define PCRS_STAT_OVF   1
`define PCRS_STAT_UNF   2
`define PCRS_CMD_PUSH   0
`define PCRS_CMD_POP    1

`endif

// [verilog/pcrs_pkg.sv]
`default_nettype none

package pcrs_pkg;

	typedef enum logic [2:0] {
		PCRS_OP_NONE,
		PCRS_OP_NEXT,
		PCRS_OP_JUMP,
		PCRS_OP_CALL,
		PCRS_OP_RET,
		PCRS_OP_INTR
	} pcrs_op_kind_type;

	typedef struct packed {
		pcrs_op_kind_type kind;
		logic [20:0]      target;
	} pcrs_core_op_type;

endpackage

`default_nettype wire

// [verilog/pcrs_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pcrs_consts.svh"

module pcrs_top
	import pcrs_pkg::*;
#(
	parameter int DEPTH     = `PCRS_DEPTH,
	parameter int DBG_DEPTH = `PCRS_DBG_DEPTH
) (
	input  wire logic             core_clk_i,
	input  wire logic             arst_n_i,
	input  wire pcrs_core_op_type core_op_i,
	input  wire logic             dbg_mode_i,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	output logic [20:0]           pc_o
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [20:0] pc_q;
	logic [7:0]  lat_h_q;
	logic [4:0]  lat_u_q;
	logic [5:0]  ptr_q;
	logic        ovf_q;
	logic        unf_q;
	logic        ready_q;
	logic [31:0] rdata_q;
	logic        slverr_q;
	// Private storage, reached only via the top-of-stack registers
	logic [20:0] stack_mem [0:DBG_DEPTH-1];

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic        acc;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [5:0]  lim;
	logic        full;
	logic        empty;
	logic [20:0] top_val;
	logic        core_push;
	logic        core_pop;
	logic        sw_push;
	logic        sw_pop;
	logic        do_push;
	logic        do_pop;
	logic [20:0] push_val;
	logic        pcl_wr;
	logic        tos_wr;

	assign acc    = psel && penable && ready_q;
	assign wr     = acc && pwrite;
	assign rd     = acc && !pwrite;
	assign mapped = (paddr == `PCRS_OFF_PCL) || (paddr == `PCRS_OFF_LATH) || (paddr == `PCRS_OFF_LATU)
		|| (paddr == `PCRS_OFF_PTR) || (paddr == `PCRS_OFF_TOP_OF_STACK_LOW) || (paddr == `PCRS_OFF_TOP_OF_STACK_HIGH)
		|| (paddr == `PCRS_OFF_TOP_OF_STACK_UPPER) || (paddr == `PCRS_OFF_STAT) || (paddr == `PCRS_OFF_CMD);

	assign lim     = dbg_mode_i ? 6'(DBG_DEPTH) : 6'(DEPTH);
	assign full    = (ptr_q >= lim);
	assign empty   = (ptr_q == `PCRS_PTR_ZERO);
	// Pointer zero has no entry behind it, so the top reads as zero there
	assign top_val = empty ? '0 : stack_mem[ptr_q - `PCRS_PTR_ONE];

	assign core_push = (core_op_i.kind == PCRS_OP_CALL) || (core_op_i.kind == PCRS_OP_INTR);
	assign core_pop  = (core_op_i.kind == PCRS_OP_RET);
	// Core requests win; a colliding software push or pop is dropped
	assign sw_push = wr && (paddr == `PCRS_OFF_CMD) && pwdata[`PCRS_CMD_PUSH] && !core_push && !core_pop;
	assign sw_pop  = wr && (paddr == `PCRS_OFF_CMD) && pwdata[`PCRS_CMD_POP] && !pwdata[`PCRS_CMD_PUSH]
		&& !core_push && !core_pop;
	assign do_push = core_push || sw_push;
	assign do_pop  = core_pop || sw_pop;
	// A call saves the address after itself; an interrupt saves the one it preempts
	assign push_val = (core_op_i.kind == PCRS_OP_CALL) ? pc_q + `PCRS_PC_STEP : pc_q;
	assign pcl_wr   = wr && (paddr == `PCRS_OFF_PCL);
	assign tos_wr   = wr && !empty && ((paddr == `PCRS_OFF_TOP_OF_STACK_LOW) || (paddr == `PCRS_OFF_TOP_OF_STACK_HIGH)
		|| (paddr == `PCRS_OFF_TOP_OF_STACK_UPPER));

	// ---------------------------------------------------------------
	// APB slave: one wait state, registered answer
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ready_q  <= 1'b0;
			rdata_q  <= '0;
			slverr_q <= 1'b0;
		end else if (psel && penable && !ready_q) begin
			ready_q  <= 1'b1;
			slverr_q <= !mapped;
			rdata_q  <= '0;
			// Read data is taken in the first access cycle, so it stands while pready is high
			if (!pwrite) begin
				unique case (paddr)
					`PCRS_OFF_PCL:  rdata_q[7:0] <= pc_q[7:0];
					`PCRS_OFF_LATH: rdata_q[7:0] <= lat_h_q;
					`PCRS_OFF_LATU: rdata_q[4:0] <= lat_u_q;
					`PCRS_OFF_PTR:  rdata_q[5:0] <= ptr_q;
					`PCRS_OFF_TOP_OF_STACK_LOW: rdata_q[7:0] <= top_val[7:0];
					`PCRS_OFF_TOP_OF_STACK_HIGH: rdata_q[7:0] <= top_val[15:8];
					`PCRS_OFF_TOP_OF_STACK_UPPER: rdata_q[4:0] <= top_val[20:16];
					`PCRS_OFF_STAT: begin
						rdata_q[`PCRS_STAT_FULL] <= full;
						rdata_q[`PCRS_STAT_OVF]  <= ovf_q;
						rdata_q[`PCRS_STAT_UNF]  <= unf_q;
					end
					default:        rdata_q <= '0;
				endcase
			end
		end else begin
			ready_q  <= 1'b0;
			slverr_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Program counter
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pc_q <= '0;
		end else if (pcl_wr) begin
			pc_q <= {lat_u_q, lat_h_q, pwdata[7:1], 1'b0};
		end else begin
			unique case (core_op_i.kind)
				PCRS_OP_NONE: pc_q <= pc_q;
				PCRS_OP_NEXT: pc_q <= pc_q + `PCRS_PC_STEP;
				PCRS_OP_JUMP,
				PCRS_OP_CALL,
				PCRS_OP_INTR: pc_q <= {core_op_i.target[20:1], 1'b0};
				PCRS_OP_RET:  pc_q <= {top_val[20:1], 1'b0};
				// Two op codes are unused; the counter holds on them
				default:      pc_q <= pc_q;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Latches: touched only by software, never by calls or returns
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lat_h_q <= '0;
			lat_u_q <= '0;
		end else if (rd && (paddr == `PCRS_OFF_PCL)) begin
			lat_h_q <= pc_q[15:8];
			lat_u_q <= pc_q[20:16];
		end else if (wr && (paddr == `PCRS_OFF_LATH)) begin
			lat_h_q <= pwdata[7:0];
		end else if (wr && (paddr == `PCRS_OFF_LATU)) begin
			lat_u_q <= pwdata[4:0];
		end
	end

	// ---------------------------------------------------------------
	// Stack pointer and sticky status
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ptr_q <= `PCRS_PTR_ZERO;
		end else if (do_push && !full) begin
			ptr_q <= ptr_q + `PCRS_PTR_ONE;
		end else if (do_pop && !empty) begin
			ptr_q <= ptr_q - `PCRS_PTR_ONE;
		end else if (wr && (paddr == `PCRS_OFF_PTR)) begin
			// Clip, not wrap: a bad restore must not alias a live entry
			ptr_q <= (pwdata[5:0] > lim) ? lim : pwdata[5:0];
		end
	end

	// Hardware set beats a same-cycle software clear
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
		end else begin
			if (do_push && full) begin
				ovf_q <= 1'b1;
			end else if (wr && (paddr == `PCRS_OFF_STAT)) begin
				ovf_q <= pwdata[`PCRS_STAT_OVF];
			end
			if (do_pop && empty) begin
				unf_q <= 1'b1;
			end else if (wr && (paddr == `PCRS_OFF_STAT)) begin
				unf_q <= pwdata[`PCRS_STAT_UNF];
			end
		end
	end

	// No reset: contents are undefined until pushed, like any RAM
	always_ff @(posedge core_clk_i) begin
		if (do_push && !full) begin
			stack_mem[ptr_q] <= push_val;
		end else if (tos_wr) begin
			unique case (paddr)
				`PCRS_OFF_TOP_OF_STACK_LOW: stack_mem[ptr_q - `PCRS_PTR_ONE][7:0]   <= pwdata[7:0];
				`PCRS_OFF_TOP_OF_STACK_HIGH: stack_mem[ptr_q - `PCRS_PTR_ONE][15:8]  <= pwdata[7:0];
				`PCRS_OFF_TOP_OF_STACK_UPPER: stack_mem[ptr_q - `PCRS_PTR_ONE][20:16] <= pwdata[4:0];
				default:        ;
			endcase
		end
	end

	assign prdata  = rdata_q;
	assign pready  = ready_q;
	assign pslverr = slverr_q;
	assign pc_o    = pc_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	chk_pc_align: assert property (pc_q[0] == 1'b0)
		else $error("pc bit zero set");
	chk_pc_step: assert property ((core_op_i.kind == PCRS_OP_NEXT) && !pcl_wr
		|=> pc_q == $past(pc_q) + `PCRS_PC_STEP)
		else $error("sequential step is not two");
	chk_pcl_load: assert property (pcl_wr
		|=> pc_q[20:8] == {$past(lat_u_q), $past(lat_h_q)})
		else $error("low byte write did not load latches");
	chk_pcl_copy: assert property (rd && (paddr == `PCRS_OFF_PCL)
		|=> (lat_h_q == $past(pc_q[15:8])) && (lat_u_q == $past(pc_q[20:16])))
		else $error("low byte read did not copy to latches");
	chk_jump_direct: assert property ((core_op_i.kind == PCRS_OP_JUMP) && !pcl_wr
		|=> pc_q == {$past(core_op_i.target[20:1]), 1'b0})
		else $error("jump target not loaded");
	chk_latch_keep: assert property ((core_push || core_pop) && !acc
		|=> $stable(lat_h_q) && $stable(lat_u_q))
		else $error("call or return changed a latch");
	chk_push_order: assert property ((core_op_i.kind == PCRS_OP_CALL) && !full
		|=> (ptr_q == $past(ptr_q) + `PCRS_PTR_ONE) && (top_val == $past(pc_q) + `PCRS_PC_STEP))
		else $error("push order wrong");
	chk_pop_order: assert property (core_pop && !empty && !pcl_wr
		|=> (pc_q == {$past(top_val[20:1]), 1'b0}) && (ptr_q == $past(ptr_q) - `PCRS_PTR_ONE))
		else $error("pop order wrong");
	chk_ovf_flag: assert property (do_push && full
		|=> ovf_q && $stable(ptr_q))
		else $error("overflow not flagged");
	chk_unf_flag: assert property (do_pop && empty |=> unf_q && (ptr_q == `PCRS_PTR_ZERO))
		else $error("underflow not flagged");
	chk_apb_wait: assert property (psel && penable && !ready_q |=> ready_q)
		else $error("apb answer late");

	// ---------------------------------------------------------------
	// Checks: latches, stack and register bus
	// ---------------------------------------------------------------
	chk_lath_write: assert property (wr && (paddr == `PCRS_OFF_LATH)
		|=> lat_h_q == $past(pwdata[7:0]))
		else $error("high latch write lost");
	chk_latu_write: assert property (wr && (paddr == `PCRS_OFF_LATU)
		|=> lat_u_q == $past(pwdata[4:0]))
		else $error("upper latch write lost");
	chk_call_target: assert property ((core_op_i.kind == PCRS_OP_CALL) && !pcl_wr
		|=> pc_q == {$past(core_op_i.target[20:1]), 1'b0})
		else $error("call target not loaded");
	chk_intr_save: assert property ((core_op_i.kind == PCRS_OP_INTR) && !full
		|=> (ptr_q == $past(ptr_q) + `PCRS_PTR_ONE) && (top_val == $past(pc_q)))
		else $error("interrupt did not save the counter");
	chk_empty_pop: assert property (core_pop && empty && !pcl_wr
		|=> pc_q == '0)
		else $error("empty pop did not clear the counter");
	chk_sw_push: assert property (sw_push && !full
		|=> (ptr_q == $past(ptr_q) + `PCRS_PTR_ONE) && (top_val == $past(pc_q)))
		else $error("software push wrong");
	chk_sw_pop: assert property (sw_pop && !empty
		|=> ptr_q == $past(ptr_q) - `PCRS_PTR_ONE)
		else $error("software pop wrong");
	chk_ptr_clip: assert property (wr && (paddr == `PCRS_OFF_PTR) && !core_push && !core_pop
		|=> (ptr_q <= $past(lim)) && ((ptr_q == $past(pwdata[5:0])) || (ptr_q == $past(lim))))
		else $error("pointer write not clipped");
	chk_tos_write: assert property (tos_wr && (paddr == `PCRS_OFF_TOP_OF_STACK_LOW) && !core_push && !core_pop
		|=> top_val[7:0] == $past(pwdata[7:0]))
		else $error("top entry write lost");
	chk_ovf_clear: assert property (wr && (paddr == `PCRS_OFF_STAT) && !(do_push && full)
		|=> ovf_q == $past(pwdata[`PCRS_STAT_OVF]))
		else $error("overflow flag write lost");
	chk_unf_clear: assert property (wr && (paddr == `PCRS_OFF_STAT) && !(do_pop && empty)
		|=> unf_q == $past(pwdata[`PCRS_STAT_UNF]))
		else $error("underflow flag write lost");

	// Read answers are looked at one edge after the first access cycle, where they stand
	chk_pcl_read: assert property (psel && penable && !ready_q && !pwrite && (paddr == `PCRS_OFF_PCL)
		|=> rdata_q[7:0] == $past(pc_q[7:0]))
		else $error("low byte read wrong");
	chk_ptr_read: assert property (psel && penable && !ready_q && !pwrite && (paddr == `PCRS_OFF_PTR)
		|=> rdata_q[5:0] == $past(ptr_q))
		else $error("pointer read wrong");
	chk_full_read: assert property (psel && penable && !ready_q && !pwrite && (paddr == `PCRS_OFF_STAT)
		|=> rdata_q[`PCRS_STAT_FULL] == $past(full))
		else $error("full bit read wrong");
	chk_slverr_map: assert property (psel && penable && !ready_q && !mapped
		|=> slverr_q && (rdata_q == '0))
		else $error("unmapped access not refused");
	chk_ready_pulse: assert property (ready_q |=> !ready_q)
		else $error("apb answer held too long");
	chk_rdata_upper: assert property (ready_q |-> (rdata_q[31:8] == '0))
		else $error("upper read data bits set");

	// ---------------------------------------------------------------
	// Cover points
	// ---------------------------------------------------------------
	cov_call_ret: cover property (core_push ##[1:20] core_pop);
	cov_full: cover property (do_push && full);
	cov_pcl_rw: cover property (rd && (paddr == `PCRS_OFF_PCL) ##[1:10] pcl_wr);
	cov_soft_push: cover property (sw_push);
	cov_dbg_deep: cover property (dbg_mode_i && (ptr_q > 6'(DEPTH)));

endmodule

`default_nettype wire

// [tb/pcrs_core_model.sv]
`timescale 1ns/10ps
`default_nettype none

module pcrs_core_model
	import pcrs_pkg::*;
(
	input  wire logic           clk_i,
	output var pcrs_core_op_type core_op_o
);
	initial core_op_o = '{PCRS_OP_NONE, 21'h000000};

	// One op, then idle; never issued while software touches the stack registers
	task automatic issue(input pcrs_op_kind_type kind, input logic [20:0] target);
		@(posedge clk_i);
		core_op_o <= '{kind, target};
		@(posedge clk_i);
		core_op_o <= '{PCRS_OP_NONE, target};
	endtask
endmodule

`default_nettype wire

// [tb/pcrs_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pcrs_consts.svh"

module pcrs_top_tb
	import pcrs_pkg::*;
;
	logic             clk = 1'b0;
	logic             arst_n = 1'b0;
	logic             dbg = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h00000000;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             last_err;
	logic [20:0]      pc;
	pcrs_core_op_type op;
	int               fail_count = 0;
	int               total_checks = 0;
	int               cyc = 0;

	always #12.5 clk = ~clk;

	pcrs_core_model pcrs_core_model_i (.clk_i(clk), .core_op_o(op));
	pcrs_top pcrs_top_i (.core_clk_i(clk), .arst_n_i(arst_n), .core_op_i(op), .dbg_mode_i(dbg),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_o(pc));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Ends when pready is seen high at an edge; the bench timeout ends a hung wait
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(1'b0, a, 32'h00000000, q);
		check(q, e);
	endtask

	task automatic op_pc(input pcrs_op_kind_type k, input logic [20:0] t, input logic [20:0] e);
		pcrs_core_model_i.issue(k, t);
		#1 check({11'h000, pc}, {11'h000, e});
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic sc_latches();
		wr(`PCRS_OFF_LATH, 32'h00000012);
		wr(`PCRS_OFF_LATU, 32'h0000001F);
		wr(`PCRS_OFF_PCL, 32'h00000035);
		#1 check({11'h000, pc}, 32'h001F1234);
		op_pc(PCRS_OP_NEXT, 21'h000000, 21'h1F1236);
		wr(`PCRS_OFF_LATH, 32'h00000000);
		wr(`PCRS_OFF_LATU, 32'h00000000);
		rd(`PCRS_OFF_PCL, 32'h00000036);
		rd(`PCRS_OFF_LATH, 32'h00000012);
		rd(`PCRS_OFF_LATU, 32'h0000001F);
	endtask

	task automatic sc_calls();
		op_pc(PCRS_OP_JUMP, 21'h000100, 21'h000100);
		op_pc(PCRS_OP_CALL, 21'h002000, 21'h002000);
		rd(`PCRS_OFF_PTR, 32'h00000001);
		rd(`PCRS_OFF_TOP_OF_STACK_LOW, 32'h00000002);
		rd(`PCRS_OFF_TOP_OF_STACK_HIGH, 32'h00000001);
		op_pc(PCRS_OP_INTR, 21'h003000, 21'h003000);
		rd(`PCRS_OFF_TOP_OF_STACK_HIGH, 32'h00000020);
		rd(`PCRS_OFF_LATH, 32'h00000012);
		op_pc(PCRS_OP_RET, 21'h000000, 21'h002000);
		rd(`PCRS_OFF_PTR, 32'h00000001);
		op_pc(PCRS_OP_RET, 21'h000000, 21'h000102);
	endtask

	task automatic sc_depth();
		for (int i = 0; i < 31; i++) begin
			pcrs_core_model_i.issue(PCRS_OP_CALL, 21'h000400);
		end
		rd(`PCRS_OFF_PTR, 32'h0000001F);
		rd(`PCRS_OFF_STAT, 32'h00000001);
		op_pc(PCRS_OP_CALL, 21'h000600, 21'h000600);
		rd(`PCRS_OFF_PTR, 32'h0000001F);
		rd(`PCRS_OFF_STAT, 32'h00000003);
		wr(`PCRS_OFF_PTR, 32'h00000000);
		op_pc(PCRS_OP_RET, 21'h000000, 21'h000000);
		rd(`PCRS_OFF_STAT, 32'h00000006);
		wr(`PCRS_OFF_STAT, 32'h00000000);
		rd(`PCRS_OFF_STAT, 32'h00000000);
		dbg <= 1'b1;
		wr(`PCRS_OFF_PTR, 32'h00000028);
		rd(`PCRS_OFF_PTR, 32'h00000023);
		wr(`PCRS_OFF_PTR, 32'h00000000);
		dbg <= 1'b0;
	endtask

	task automatic sc_soft_stack();
		op_pc(PCRS_OP_JUMP, 21'h000A51, 21'h000A50);
		wr(`PCRS_OFF_CMD, 32'h00000001);
		rd(`PCRS_OFF_PTR, 32'h00000001);
		rd(`PCRS_OFF_TOP_OF_STACK_LOW, 32'h00000050);
		wr(`PCRS_OFF_TOP_OF_STACK_LOW, 32'h00000044);
		rd(`PCRS_OFF_TOP_OF_STACK_LOW, 32'h00000044);
		wr(`PCRS_OFF_CMD, 32'h00000002);
		rd(`PCRS_OFF_PTR, 32'h00000000);
		rd(8'h40, 32'h00000000);
		check({31'h00000000, last_err}, 32'h00000001);
	endtask

	// Reset in mid-run: pointer, flags and counter return to zero
	task automatic sc_reset();
		op_pc(PCRS_OP_CALL, 21'h000700, 21'h000700);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		#1 check({11'h000, pc}, 32'h00000000);
		rd(`PCRS_OFF_PTR, 32'h00000000);
		rd(`PCRS_OFF_TOP_OF_STACK_LOW, 32'h00000000);
		rd(`PCRS_OFF_STAT, 32'h00000000);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		#1 check({11'h000, pc}, 32'h00000000);
		rd(`PCRS_OFF_PTR, 32'h00000000);
		sc_latches();
		sc_calls();
		sc_depth();
		sc_soft_stack();
		sc_reset();
		summarize();
	end
endmodule

`default_nettype wire
